// [rtl/dcps_scheduler.sv]
// dcps_scheduler: picks which of two channels runs the next internal cycle
//
// Functional notes
// - decide next channel every cycle, no overhead
// - dma, termination, chained=1; attention 2; program 3
// - chain flag raises program to dma priority
// - grant channel with highest activity priority
// - equal priority: tie-break bit one wins
// - tie-break loaded from command word bit
// - equal priority and bits: alternate channels
// - dma preempts instructions at internal cycles
// - dma interleaves other dma per bus cycle
// - two programs switch at instruction boundaries
// - termination/attention not interrupted by instructions
// - lock blocks dma interleave, dma keeps running
// - locked test-and-set finishes before other dma
// - arbitrate when both channels ready, else run the active one
// - blocked attention latched, runs when allowed
// - termination routine adjusts the task pointer
// - attention routine reads, executes command word
// - internal routine fetches stay off bus
// - dma yields to attention after transfer cycle
// - chained program gets cycle after dma; code keeps dma if its tie-break bit is one and the program's zero
// - started attention continues, else chained program
// - chain flag is channel_control bit eight
// - lock held: running channel keeps processor
//
// Local design decisions: the strobed register port and the register addresses.
`default_nettype none
module dcps_scheduler (
    input  wire logic                   core_clk_in,
    input  wire logic                   reset_n_in,
    // per channel activity, from the channel sequencers
    input  wire dcps_pkg::dcps_act_t    ch0_act_in,
    input  wire dcps_pkg::dcps_act_t    ch1_act_in,
    // channel_control words (chain flag)
    input  wire logic [15:0]            ch0_channel_control_in,
    input  wire logic [15:0]            ch1_channel_control_in,
    // attention_request from the host, one pulse per channel
    input  wire logic                   ch0_attention_request_in,
    input  wire logic                   ch1_attention_request_in,
    // channel_command_word being executed by the attention routine
    input  wire logic [7:0]             channel_command_word_in,
    input  wire logic                   cmd_load_ch0_in,
    input  wire logic                   cmd_load_ch1_in,
    // boundary markers for the channel currently running
    input  wire logic                   bus_cycle_end_in,
    input  wire logic                   instr_end_in,
    input  wire logic                   seq_started_in,
    input  wire logic                   term_done_in,
    input  wire logic                   attn_done_in,
    input  wire logic                   tsl_active_in,
    // bus lock as driven by the running channel
    input  wire logic                   bus_lock_in,
    // register port
    input  wire logic [3:0]             reg_addr_in,
    input  wire logic [15:0]            reg_wdata_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    output logic [15:0]                 reg_rdata_out,
    // grant
    output logic                        run_ch1_out,
    output logic                        ch0_attn_pending_out,
    output logic                        ch1_attn_pending_out,
    output logic                        rom_fetch_out,
    output logic                        tp_adjust_out,
    output logic                        cmd_fetch_out,
    output logic [1:0]                  program_state_prio_out
);

    // ----------------------------------------------------------------
    // activity to priority
    // ----------------------------------------------------------------
    function automatic logic [2:0] act_pri(input dcps_pkg::dcps_act_t act,
                                           input logic chain);
        logic [2:0] p;
        p = dcps_pkg::DCPS_PRI_IDLE;
        case (act)
            dcps_pkg::DCPS_ACT_DMA_XFER:  p = dcps_pkg::DCPS_PRI_TOP;
            dcps_pkg::DCPS_ACT_DMA_TERM:  p = dcps_pkg::DCPS_PRI_TOP;
            dcps_pkg::DCPS_ACT_ATTENTION: p = dcps_pkg::DCPS_PRI_ATTN;
            // chained program runs at dma level
            dcps_pkg::DCPS_ACT_PROGRAM:
                p = chain ? dcps_pkg::DCPS_PRI_TOP : dcps_pkg::DCPS_PRI_PROGRAM;
            default:                      p = dcps_pkg::DCPS_PRI_IDLE;
        endcase
        return p;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic        last_ch;
    logic        next_last_ch;
    logic [1:0]  prio_bit;
    logic [1:0]  next_prio_bit;
    logic [1:0]  attn_latch;
    logic [1:0]  next_attn_latch;
    logic [1:0]  sw_hold;
    logic [1:0]  next_sw_hold;
    logic        alt_owed;
    logic        next_alt_owed;
    logic [15:0] next_rdata;
    logic        next_rom_fetch;
    logic        next_tp_adjust;
    logic        next_cmd_fetch;

    dcps_pkg::dcps_act_t act_a;
    dcps_pkg::dcps_act_t act_b;
    logic [2:0]          pri_a;
    logic [2:0]          pri_b;
    logic                chain_a;
    logic                chain_b;
    logic                pb_a;
    logic                pb_b;
    logic                b_wins;
    logic                at_boundary;
    logic                switch_ok;
    logic                run_ch;

    // ----------------------------------------------------------------
    // switch decision
    // ----------------------------------------------------------------
    always_comb begin
        // incumbent is the channel that ran last
        act_a   = last_ch ? ch1_act_in : ch0_act_in;
        act_b   = last_ch ? ch0_act_in : ch1_act_in;
        chain_a = last_ch ? ch1_channel_control_in[dcps_pkg::DCPS_CHAIN_BIT]
                          : ch0_channel_control_in[dcps_pkg::DCPS_CHAIN_BIT];
        chain_b = last_ch ? ch0_channel_control_in[dcps_pkg::DCPS_CHAIN_BIT]
                          : ch1_channel_control_in[dcps_pkg::DCPS_CHAIN_BIT];
        pb_a    = prio_bit[last_ch];
        pb_b    = prio_bit[~last_ch];
        pri_a   = act_pri(act_a, chain_a);
        pri_b   = act_pri(act_b, chain_b);

        if (pri_b < pri_a) begin
            b_wins = 1'b1;
        end else if (pri_b > pri_a) begin
            b_wins = 1'b0;
        end else if (pb_b != pb_a) begin
            b_wins = pb_b;
        end else begin
            b_wins = 1'b1;
        end

        if (act_a == dcps_pkg::DCPS_ACT_DMA_XFER &&
            act_b == dcps_pkg::DCPS_ACT_ATTENTION) begin
            b_wins = 1'b1;
        end
        // chained program after each dma bus cycle, when both tie-break bits are one
        if (act_a == dcps_pkg::DCPS_ACT_DMA_XFER && pb_a &&
            act_b == dcps_pkg::DCPS_ACT_PROGRAM && chain_b && pb_b) begin
            b_wins = 1'b1;
        end
        // unstarted attention loses to chained program
        if (act_a == dcps_pkg::DCPS_ACT_ATTENTION &&
            act_b == dcps_pkg::DCPS_ACT_PROGRAM && chain_b) begin
            b_wins = ~seq_started_in;
        end

        // interleave boundary of the incumbent
        at_boundary = 1'b1;
        case (act_a)
            // dma yields after a bus cycle
            dcps_pkg::DCPS_ACT_DMA_XFER:  at_boundary = bus_cycle_end_in;
            dcps_pkg::DCPS_ACT_DMA_TERM,
            dcps_pkg::DCPS_ACT_ATTENTION:
                at_boundary = (act_b == dcps_pkg::DCPS_ACT_DMA_XFER) ? 1'b1
                            : (act_a == dcps_pkg::DCPS_ACT_DMA_TERM ? term_done_in
                                                                    : attn_done_in);
            // dma preempts at internal cycles; else instr end
            dcps_pkg::DCPS_ACT_PROGRAM:
                at_boundary = (act_b == dcps_pkg::DCPS_ACT_DMA_XFER) ? ~tsl_active_in
                                                                     : instr_end_in;
            default:                      at_boundary = 1'b1;
        endcase
        // started attention keeps running, unstarted one yields
        if (act_a == dcps_pkg::DCPS_ACT_ATTENTION &&
            act_b == dcps_pkg::DCPS_ACT_PROGRAM) begin
            at_boundary = seq_started_in ? attn_done_in : 1'b1;
        end

        // both ready, else the active one
        if (act_b == dcps_pkg::DCPS_ACT_IDLE) begin
            switch_ok = 1'b0;
        end else if (act_a == dcps_pkg::DCPS_ACT_IDLE) begin
            switch_ok = 1'b1;
        end else if (bus_lock_in) begin
            switch_ok = 1'b0;
        end else begin
            switch_ok = b_wins && at_boundary;
        end
        // alternation only after a boundary was honoured
        if (switch_ok && pri_a == pri_b && pb_a == pb_b && !alt_owed &&
            act_a != dcps_pkg::DCPS_ACT_IDLE) begin
            switch_ok = 1'b1;
        end

        // decision applied on this edge, no gap
        run_ch       = switch_ok ? ~last_ch : last_ch;
        next_last_ch = run_ch;
        next_alt_owed = 1'b0;
        next_sw_hold  = sw_hold;
    end

    // ----------------------------------------------------------------
    // attention latch and tie-break bits
    // ----------------------------------------------------------------
    always_comb begin
        next_attn_latch = attn_latch;
        next_prio_bit   = prio_bit;
        // clear when routine ends; new request wins
        if (attn_done_in) begin
            next_attn_latch[last_ch] = 1'b0;
        end
        if (ch0_attention_request_in) begin
            next_attn_latch[0] = 1'b1;
        end
        if (ch1_attention_request_in) begin
            next_attn_latch[1] = 1'b1;
        end
        if (cmd_load_ch0_in) begin
            next_prio_bit[0] = channel_command_word_in[dcps_pkg::DCPS_CMD_PRIO_BIT];
        end
        if (cmd_load_ch1_in) begin
            next_prio_bit[1] = channel_command_word_in[dcps_pkg::DCPS_CMD_PRIO_BIT];
        end
        if (reg_wr_in && reg_addr_in == dcps_pkg::DCPS_REG_CTRL0) begin
            next_prio_bit[0] = reg_wdata_in[0];
        end else if (reg_wr_in && reg_addr_in == dcps_pkg::DCPS_REG_CTRL1) begin
            next_prio_bit[1] = reg_wdata_in[0];
        end
    end

    // ----------------------------------------------------------------
    // internal routine controls and register read
    // ----------------------------------------------------------------
    always_comb begin
        dcps_pkg::dcps_act_t act_run;
        act_run = run_ch ? ch1_act_in : ch0_act_in;
        // internal routines fetch from on-chip store
        next_rom_fetch = (act_run == dcps_pkg::DCPS_ACT_DMA_TERM) ||
                         (act_run == dcps_pkg::DCPS_ACT_ATTENTION);
        next_tp_adjust = (act_run == dcps_pkg::DCPS_ACT_DMA_TERM);
        next_cmd_fetch = (act_run == dcps_pkg::DCPS_ACT_ATTENTION);
        next_rdata     = reg_rdata_out;
        if (reg_rd_in) begin
            if (reg_addr_in == dcps_pkg::DCPS_REG_CTRL0) begin
                next_rdata = {15'h0000, prio_bit[0]};
            end else if (reg_addr_in == dcps_pkg::DCPS_REG_CTRL1) begin
                next_rdata = {15'h0000, prio_bit[1]};
            end else if (reg_addr_in == dcps_pkg::DCPS_REG_STATUS) begin
                next_rdata = {11'h000, attn_latch, prio_bit, last_ch};
            end else begin
                next_rdata = 16'h0000;
            end
        end else begin
            next_rdata = 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // last channel, tie-break bits, attention latches and output registers
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            last_ch                <= dcps_pkg::DCPS_LAST_RESET;
            prio_bit               <= dcps_pkg::DCPS_PRIO_RESET;
            attn_latch             <= 2'h0;
            sw_hold                <= 2'h0;
            alt_owed               <= 1'b0;
            reg_rdata_out          <= 16'h0000;
            run_ch1_out            <= 1'b0;
            ch0_attn_pending_out   <= 1'b0;
            ch1_attn_pending_out   <= 1'b0;
            rom_fetch_out          <= 1'b0;
            tp_adjust_out          <= 1'b0;
            cmd_fetch_out          <= 1'b0;
            program_state_prio_out <= 2'h0;
        end else begin
            last_ch                <= next_last_ch;
            prio_bit               <= next_prio_bit;
            attn_latch             <= next_attn_latch;
            sw_hold                <= next_sw_hold;
            alt_owed               <= next_alt_owed;
            reg_rdata_out          <= next_rdata;
            run_ch1_out            <= next_last_ch;
            ch0_attn_pending_out   <= next_attn_latch[0];
            ch1_attn_pending_out   <= next_attn_latch[1];
            rom_fetch_out          <= next_rom_fetch;
            tp_adjust_out          <= next_tp_adjust;
            cmd_fetch_out          <= next_cmd_fetch;
            program_state_prio_out <= next_prio_bit;
        end
    end

endmodule // dcps_scheduler
`default_nettype wire

// [rtl/dcps_pkg.sv]
// dcps_pkg: constants and types for the two-channel scheduler
`default_nettype none
package dcps_pkg;
    // activity codes presented by each channel
    typedef enum logic [2:0] {
        DCPS_ACT_IDLE,
        DCPS_ACT_DMA_XFER,
        DCPS_ACT_DMA_TERM,
        DCPS_ACT_PROGRAM,
        DCPS_ACT_ATTENTION
    } dcps_act_t;

    // priority levels, 1 highest
    localparam logic [2:0] DCPS_PRI_TOP     = 3'h1;
    localparam logic [2:0] DCPS_PRI_ATTN    = 3'h2;
    localparam logic [2:0] DCPS_PRI_PROGRAM = 3'h3;
    localparam logic [2:0] DCPS_PRI_IDLE    = 3'h4;

    // chain flag position in the channel_control word
    localparam int unsigned DCPS_CHAIN_BIT = 8;
    // tie-break position in the channel_command_word
    localparam int unsigned DCPS_CMD_PRIO_BIT = 5;

    // register bus map (word offsets of a plain port)
    localparam logic [3:0] DCPS_REG_CTRL0   = 4'h0;
    localparam logic [3:0] DCPS_REG_CTRL1   = 4'h1;
    localparam logic [3:0] DCPS_REG_STATUS  = 4'h2;

    // values after reset
    localparam logic       DCPS_LAST_RESET  = 1'b0;
    localparam logic [1:0] DCPS_PRIO_RESET  = 2'h0;
endpackage : dcps_pkg
`default_nettype wire

// [test/dcps_sched_asserts.sv]
// dcps_sched_asserts: port checks for the two-channel scheduler
`default_nettype none
module dcps_sched_asserts (
    input wire logic                core_clk_in,
    input wire logic                reset_n_in,
    input wire dcps_pkg::dcps_act_t ch0_act_in,
    input wire dcps_pkg::dcps_act_t ch1_act_in,
    input wire logic [15:0]         ch0_channel_control_in,
    input wire logic [15:0]         ch1_channel_control_in,
    input wire logic                ch1_attention_request_in,
    input wire logic                bus_cycle_end_in,
    input wire logic                instr_end_in,
    input wire logic                term_done_in,
    input wire logic                bus_lock_in,
    input wire logic                run_ch1_out,
    input wire logic                ch1_attn_pending_out,
    input wire logic [1:0]          program_state_prio_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    // ----------------------------------------
    // incumbent and challenger views
    // ----------------------------------------
    dcps_pkg::dcps_act_t cur_a;
    dcps_pkg::dcps_act_t oth_a;
    logic                cur_ch;
    logic                cur_b;
    logic                oth_b;
    assign cur_a  = run_ch1_out ? ch1_act_in : ch0_act_in;
    assign oth_a  = run_ch1_out ? ch0_act_in : ch1_act_in;
    assign cur_ch = run_ch1_out ? ch1_channel_control_in[dcps_pkg::DCPS_CHAIN_BIT]
                                : ch0_channel_control_in[dcps_pkg::DCPS_CHAIN_BIT];
    assign cur_b  = program_state_prio_out[run_ch1_out];
    assign oth_b  = program_state_prio_out[!run_ch1_out];
    // ----------------------------------------
    // properties
    // ----------------------------------------
    sequence s_dma_pair;
        !bus_lock_in && bus_cycle_end_in && cur_a == dcps_pkg::DCPS_ACT_DMA_XFER
            && oth_a == dcps_pkg::DCPS_ACT_DMA_XFER;
    endsequence
    sequence s_prog_pair;
        !bus_lock_in && cur_a == dcps_pkg::DCPS_ACT_PROGRAM
            && oth_a == dcps_pkg::DCPS_ACT_PROGRAM;
    endsequence
    property p_lock;
        bus_lock_in && cur_a != dcps_pkg::DCPS_ACT_IDLE |=> $stable(run_ch1_out);
    endproperty
    property p_idle;
        cur_a != dcps_pkg::DCPS_ACT_IDLE && oth_a == dcps_pkg::DCPS_ACT_IDLE
            |=> $stable(run_ch1_out);
    endproperty
    property p_preempt;
        !bus_lock_in && cur_a == dcps_pkg::DCPS_ACT_PROGRAM && !cur_ch
            && oth_a == dcps_pkg::DCPS_ACT_DMA_XFER |=> $changed(run_ch1_out);
    endproperty
    property p_tie;
        s_dma_pair ##0 (!cur_b && oth_b) |=> $changed(run_ch1_out);
    endproperty
    property p_alt;
        s_dma_pair ##0 (cur_b == oth_b) |=> $changed(run_ch1_out);
    endproperty
    property p_instr;
        s_prog_pair ##0 !instr_end_in |=> $stable(run_ch1_out);
    endproperty
    property p_term;
        cur_a == dcps_pkg::DCPS_ACT_DMA_TERM && oth_a == dcps_pkg::DCPS_ACT_PROGRAM
            && !term_done_in |=> $stable(run_ch1_out);
    endproperty
    property p_attn;
        ch1_attention_request_in |=> ch1_attn_pending_out;
    endproperty
    a_lock: assert property (p_lock) else $error("switch under lock");
    a_idle: assert property (p_idle) else $error("idle channel took cycle");
    a_preempt: assert property (p_preempt) else $error("dma did not preempt");
    a_tie: assert property (p_tie) else $error("tie-break loser kept running");
    a_alt: assert property (p_alt) else $error("no alternation on dma");
    a_instr: assert property (p_instr) else $error("switch inside instruction");
    a_term: assert property (p_term) else $error("termination interrupted");
    a_attn: assert property (p_attn) else $error("attention not latched");
endmodule // dcps_sched_asserts
bind dcps_scheduler dcps_sched_asserts u_chk (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .ch0_act_in(ch0_act_in), .ch1_act_in(ch1_act_in),
    .ch0_channel_control_in(ch0_channel_control_in),
    .ch1_channel_control_in(ch1_channel_control_in),
    .ch1_attention_request_in(ch1_attention_request_in),
    .bus_cycle_end_in(bus_cycle_end_in), .instr_end_in(instr_end_in),
    .term_done_in(term_done_in), .bus_lock_in(bus_lock_in), .run_ch1_out(run_ch1_out),
    .ch1_attn_pending_out(ch1_attn_pending_out),
    .program_state_prio_out(program_state_prio_out));
`default_nettype wire

// [test/dcps_host_model.sv]
// dcps_host_model: host side raising attentions and command words
`default_nettype none
module dcps_host_model (
    input  wire logic  core_clk_in,
    output logic       att0_out,
    output logic       att1_out,
    output logic [7:0] ccw_out,
    output logic       load0_out,
    output logic       load1_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {att0_out, att1_out, load0_out, load1_out} = 4'h0;
        ccw_out = 8'h00;
    end
    task automatic attend(input logic ch);
        @(posedge core_clk_in);
        att0_out <= !ch;
        att1_out <= ch;
        @(posedge core_clk_in);
        {att0_out, att1_out} <= 2'h0;
    endtask
    task automatic command(input logic ch, input logic pb);
        @(posedge core_clk_in);
        ccw_out <= 8'(pb) << dcps_pkg::DCPS_CMD_PRIO_BIT;
        load0_out <= !ch;
        load1_out <= ch;
        @(posedge core_clk_in);
        {load0_out, load1_out} <= 2'h0;
        // word no longer held: show the inverse
        ccw_out <= ~ccw_out;
    endtask
endmodule // dcps_host_model
`default_nettype wire

// [test/tb_top.sv]
// tb_top: scheduler testbench with host model
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                core_clk_in, reset_n_in;
    dcps_pkg::dcps_act_t a0, a1;
    logic [15:0]         cc0, cc1, wdat, rdat;
    logic [7:0]          channel_command_word;
    logic [3:0]          addr;
    logic                att0, att1, ld0, ld1, bce, ie, test_and_set_instruction, lock, wr, rd, run1, pend1;
    logic [1:0]          pb;
    logic                ss, td, tpa, rom, cmdf, pend0;
    int                  err_count, compares;
    dcps_host_model host (.core_clk_in(core_clk_in), .att0_out(att0), .att1_out(att1),
        .ccw_out(channel_command_word), .load0_out(ld0), .load1_out(ld1));
    dcps_scheduler dut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
        .ch0_act_in(a0), .ch1_act_in(a1), .ch0_channel_control_in(cc0),
        .ch1_channel_control_in(cc1), .ch0_attention_request_in(att0),
        .ch1_attention_request_in(att1), .channel_command_word_in(channel_command_word),
        .cmd_load_ch0_in(ld0), .cmd_load_ch1_in(ld1), .bus_cycle_end_in(bce),
        .instr_end_in(ie), .seq_started_in(ss), .term_done_in(td), .attn_done_in(1'b0),
        .tsl_active_in(test_and_set_instruction), .bus_lock_in(lock), .reg_addr_in(addr), .reg_wdata_in(wdat),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .run_ch1_out(run1),
        .ch0_attn_pending_out(pend0), .ch1_attn_pending_out(pend1), .rom_fetch_out(rom),
        .tp_adjust_out(tpa), .cmd_fetch_out(cmdf), .program_state_prio_out(pb));
    task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic end_of_test();
        if (err_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    task automatic drive(input dcps_pkg::dcps_act_t x0, input dcps_pkg::dcps_act_t x1);
        @(posedge core_clk_in);
        a0 <= x0;
        a1 <= x1;
        tick(1);
    endtask
    // one boundary pulse: instruction end or bus cycle end
    task automatic bound(input logic instr);
        @(posedge core_clk_in);
        ie <= instr;
        bce <= !instr;
        @(posedge core_clk_in);
        {ie, bce} <= 2'h0;
        #1;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk_in);
        {wr, addr, wdat} <= {1'b1, a, d};
        @(posedge core_clk_in);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp, input string n);
        @(posedge core_clk_in);
        {rd, addr} <= {1'b1, a};
        @(posedge core_clk_in);
        rd <= 1'b0;
        #1 chk(n, rdat, exp);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        reg_rd(dcps_pkg::DCPS_REG_STATUS, 16'h0000, "status");
        reg_wr(dcps_pkg::DCPS_REG_CTRL0, 16'h0001);
        reg_wr(4'hf, 16'hffff);
        reg_rd(dcps_pkg::DCPS_REG_CTRL0, 16'h0001, "ctrl0");
        reg_rd(dcps_pkg::DCPS_REG_STATUS, 16'h0002, "status_pb");
        reg_rd(4'hf, 16'h0000, "unmapped");
        reg_wr(dcps_pkg::DCPS_REG_CTRL0, 16'h0000);
    endtask
    task automatic t_preempt();
        drive(dcps_pkg::DCPS_ACT_PROGRAM, dcps_pkg::DCPS_ACT_DMA_XFER);
        chk("preempt", 16'(run1), 16'h1);
        drive(dcps_pkg::DCPS_ACT_PROGRAM, dcps_pkg::DCPS_ACT_IDLE);
        tick(3);
        chk("idle_other", 16'(run1), 16'h0);
    endtask
    task automatic t_dma_tie();
        drive(dcps_pkg::DCPS_ACT_DMA_XFER, dcps_pkg::DCPS_ACT_DMA_XFER);
        host.command(1'b1, 1'b1);
        #1 chk("pb_load", 16'(pb), 16'h2);
        bound(1'b0);
        bound(1'b0);
        chk("tie_win", 16'(run1), 16'h1);
        host.command(1'b1, 1'b0);
        bound(1'b0);
        chk("alt0", 16'(run1), 16'h0);
        bound(1'b0);
        chk("alt1", 16'(run1), 16'h1);
    endtask
    task automatic t_lock();
        drive(dcps_pkg::DCPS_ACT_DMA_XFER, dcps_pkg::DCPS_ACT_IDLE);
        @(posedge core_clk_in);
        lock <= 1'b1;
        drive(dcps_pkg::DCPS_ACT_DMA_XFER, dcps_pkg::DCPS_ACT_ATTENTION);
        bound(1'b0);
        chk("lock_dma", 16'(run1), 16'h0);
        @(posedge core_clk_in);
        lock <= 1'b0;
        bound(1'b0);
        chk("attn_yield", 16'(run1), 16'h1);
        drive(dcps_pkg::DCPS_ACT_PROGRAM, dcps_pkg::DCPS_ACT_IDLE);
        @(posedge core_clk_in);
        {lock, test_and_set_instruction} <= 2'h3;
        drive(dcps_pkg::DCPS_ACT_PROGRAM, dcps_pkg::DCPS_ACT_DMA_XFER);
        tick(2);
        chk("tsl_hold", 16'(run1), 16'h0);
        @(posedge core_clk_in);
        {lock, test_and_set_instruction} <= 2'h0;
        bound(1'b1);
        chk("tsl_done", 16'(run1), 16'h1);
    endtask
    task automatic t_prog();
        drive(dcps_pkg::DCPS_ACT_PROGRAM, dcps_pkg::DCPS_ACT_IDLE);
        drive(dcps_pkg::DCPS_ACT_PROGRAM, dcps_pkg::DCPS_ACT_PROGRAM);
        tick(2);
        chk("instr_wait", 16'(run1), 16'h0);
        bound(1'b1);
        chk("instr_sw", 16'(run1), 16'h1);
        @(posedge core_clk_in);
        cc0 <= 16'h0100;
        bound(1'b1);
        bound(1'b1);
        chk("chained", 16'(run1), 16'h0);
        host.attend(1'b1);
        #1 chk("attn_latch", 16'(pend1), 16'h1);
        @(posedge core_clk_in);
        {cc0, cc1} <= {16'h0000, 16'h0100};
        drive(dcps_pkg::DCPS_ACT_DMA_TERM, dcps_pkg::DCPS_ACT_PROGRAM);
        bound(1'b1);
        chk("term_hold", 16'(run1), 16'h0);
    endtask
    task automatic t_routines();
        chk("tp_adjust", 16'(tpa), 16'h1);
        chk("rom_term", 16'(rom), 16'h1);
        @(posedge core_clk_in);
        td <= 1'b1;
        @(posedge core_clk_in);
        td <= 1'b0;
        #1 chk("term_done", 16'(run1), 16'h1);
        chk("rom_prog", 16'(rom), 16'h0);
        @(posedge core_clk_in);
        {ss, cc0} <= {1'b1, 16'h0100};
        drive(dcps_pkg::DCPS_ACT_PROGRAM, dcps_pkg::DCPS_ACT_ATTENTION);
        chk("attn_started", 16'(run1), 16'h1);
        chk("cmd_fetch", 16'(cmdf), 16'h1);
        @(posedge core_clk_in);
        ss <= 1'b0;
        tick(1);
        chk("attn_unstarted", 16'(run1), 16'h0);
        host.attend(1'b0);
        #1 chk("attn_latch0", 16'(pend0), 16'h1);
    endtask
    initial begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end
    initial begin
        repeat (5000) @(posedge core_clk_in);
        err_count++;
        end_of_test();
    end
    initial begin
        {reset_n_in, bce, ie, test_and_set_instruction, lock, wr, rd, ss, td} = 9'h000;
        {cc0, cc1, wdat, addr} = 52'h0;
        {a0, a1} = {dcps_pkg::DCPS_ACT_IDLE, dcps_pkg::DCPS_ACT_IDLE};
        repeat (12) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        t_regs();
        t_preempt();
        t_dma_tie();
        t_lock();
        t_prog();
        t_routines();
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
